/* design/sfwp_core.sv */
`timescale 1ns/100ps

module sfwp_core (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // power-up reset, active low
  input wire logic serial_clock, // link clock from host
  input wire logic select_n, // chip select, active low
  input wire logic write_protect_n, // protect pin, active low
  input wire logic dual_lane0_i, // serial in / lane 0 in
  output logic dual_lane0_o, // lane 0 out
  output logic dual_lane0_oe, // lane 0 drive enable
  output logic dual_lane1_o, // serial out / lane 1
  output logic dual_lane1_oe, // lane 1 drive enable
  input wire logic [7:0] array_byte, // dual read data, link domain
  output sfwp_pkg::sfwp_status_t status_o, // status byte
  output logic deep_pd_o, // deep power-down state
  output sfwp_pkg::sfwp_arr_cmd_t arr_cmd_o // accepted array operation pulse
);

  // ********************************************************
  // link side, rising edge
  // ********************************************************
  logic lrst_n;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [2:0] nby_q, nby_d;
  logic [6:0] sh_q, sh_d;
  logic [7:0] op_q, op_d;
  logic [7:0] byte_q, byte_d;
  logic byte_tgl_q, byte_tgl_d;
  logic bit_tgl_q, bit_tgl_d;
  sfwp_pkg::sfwp_shadow_t shadow_q, shadow_d;

  // select high holds the frame logic idle, either clock idle level works
  assign lrst_n = rstn & ~select_n;

  always_comb begin
    bit_cnt_d = bit_cnt_q + 3'h1;
    sh_d = {sh_q[5:0], dual_lane0_i};
    nby_d = nby_q;
    op_d = op_q;
    if (bit_cnt_q == 3'h7) begin
      nby_d = (nby_q == 3'h7) ? nby_q : nby_q + 3'h1;
      if (nby_q == 3'h0) begin
        op_d = {sh_q, dual_lane0_i};
      end
    end
  end

  always_ff @(posedge serial_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_cnt_q <= 3'h0;
      nby_q <= 3'h0;
      sh_q <= 7'h00;
      op_q <= 8'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      nby_q <= nby_d;
      sh_q <= sh_d;
      op_q <= op_d;
    end
  end

  // toggles survive deselect so the system side sees no false event
  always_comb begin
    bit_tgl_d = bit_tgl_q ^ ~select_n;
    byte_tgl_d = byte_tgl_q;
    byte_d = byte_q;
    if (!select_n && bit_cnt_q == 3'h7) begin
      byte_d = {sh_q, dual_lane0_i};
      byte_tgl_d = ~byte_tgl_q;
    end
  end

  always_ff @(posedge serial_clock or negedge rstn) begin
    if (!rstn) begin
      bit_tgl_q <= 1'b0;
      byte_tgl_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      bit_tgl_q <= bit_tgl_d;
      byte_tgl_q <= byte_tgl_d;
      byte_q <= byte_d;
    end
  end

  // ********************************************************
  // link side, falling edge
  // ********************************************************
  logic [7:0] out_q, out_d;
  logic l0_q, l0_d, l0_oe_q, l0_oe_d, l1_q, l1_d, l1_oe_q, l1_oe_d;
  logic rd_st, rd_dual;
  logic [7:0] st_byte;

  // shadow is refreshed only while deselected and mid-byte, so it is stable at each load edge
  assign st_byte = shadow_q.st;
  assign rd_st = !shadow_q.dpd && op_q == sfwp_pkg::SFWP_OPC_ST_READ && nby_q != 3'h0;
  assign rd_dual = !shadow_q.dpd && op_q == sfwp_pkg::SFWP_OPC_DUAL_RD && nby_q >= sfwp_pkg::SFWP_LEN_ADDR_DATA;

  always_comb begin
    out_d = {out_q[6:0], 1'b0};
    l1_d = out_q[7];
    l0_d = 1'b0;
    l1_oe_d = rd_st | rd_dual;
    l0_oe_d = rd_dual;
    if (rd_dual) begin
      if (bit_cnt_q[1:0] == 2'h0) begin
        l1_d = array_byte[7];
        l0_d = array_byte[6];
        out_d = {array_byte[5:0], 2'h0};
      end else begin
        l1_d = out_q[7];
        l0_d = out_q[6];
        out_d = {out_q[5:0], 2'h0};
      end
    end else if (rd_st && bit_cnt_q == 3'h0) begin
      l1_d = st_byte[7];
      out_d = {st_byte[6:0], 1'b0};
    end
  end

  always_ff @(negedge serial_clock or negedge lrst_n) begin
    if (!lrst_n) begin
      out_q <= 8'h00;
      l0_q <= 1'b0;
      l0_oe_q <= 1'b0;
      l1_q <= 1'b0;
      l1_oe_q <= 1'b0;
    end else begin
      out_q <= out_d;
      l0_q <= l0_d;
      l0_oe_q <= l0_oe_d;
      l1_q <= l1_d;
      l1_oe_q <= l1_oe_d;
    end
  end

  assign dual_lane0_o = l0_q;
  assign dual_lane0_oe = l0_oe_q;
  assign dual_lane1_o = l1_q;
  assign dual_lane1_oe = l1_oe_q;

  // ********************************************************
  // system side, synchronisers
  // ********************************************************
  logic [2:0] cs_s_q, bt_s_q, by_s_q;
  logic [1:0] wp_s_q;
  logic cs_fall, cs_rise, bit_ev, byte_ev, hw_lock;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_s_q <= 3'h7;
      bt_s_q <= 3'h0;
      by_s_q <= 3'h0;
      wp_s_q <= 2'h3;
    end else begin
      cs_s_q <= {cs_s_q[1:0], select_n};
      bt_s_q <= {bt_s_q[1:0], bit_tgl_q};
      by_s_q <= {by_s_q[1:0], byte_tgl_q};
      wp_s_q <= {wp_s_q[0], write_protect_n};
    end
  end

  assign cs_fall = cs_s_q[2] & ~cs_s_q[1];
  assign cs_rise = ~cs_s_q[2] & cs_s_q[1];
  assign bit_ev = bt_s_q[1] ^ bt_s_q[2];
  assign byte_ev = by_s_q[1] ^ by_s_q[2];

  // ********************************************************
  // system side, command evaluation and status
  // ********************************************************
  logic [2:0] fbits_q, fbits_d, fbytes_q, fbytes_d;
  logic [7:0] fop_q, fop_d, fdata_q, fdata_d;
  logic [23:0] faddr_q, faddr_d;
  sfwp_pkg::sfwp_status_t st_q, st_d, pend_q, pend_d;
  logic dpd_q, dpd_d, pend_sr_q, pend_sr_d;
  logic [15:0] cnt_q, cnt_d;
  sfwp_pkg::sfwp_arr_cmd_t arr_q, arr_d;
  logic go, go_sr;
  sfwp_pkg::sfwp_arr_kind_t kind;
  logic [7:0] lo_sect, hi_sect;
  logic prot_lo, prot_hi, full_ok;

  assign lo_sect = faddr_q[sfwp_pkg::SFWP_SECT_MSB:sfwp_pkg::SFWP_SECT_LSB];
  assign hi_sect = lo_sect | ((fop_q == sfwp_pkg::SFWP_OPC_64K_ER) ? sfwp_pkg::SFWP_B64_SECT_MASK :
                   (fop_q == sfwp_pkg::SFWP_OPC_32K_ER) ? sfwp_pkg::SFWP_B32_SECT_MASK : 8'h00);
  assign hw_lock = st_q.status_lock_mode & ~wp_s_q[1];

  sfwp_prot_dec u_dec_lo (
    .size_bits(st_q.protect_size_bits),
    .compl(st_q.complement_protect),
    .sector(lo_sect),
    .prot(prot_lo),
    .full_er_ok(full_ok)
  );

  sfwp_prot_dec u_dec_hi (
    .size_bits(st_q.protect_size_bits),
    .compl(st_q.complement_protect),
    .sector(hi_sect),
    .prot(prot_hi),
    .full_er_ok()
  );

  always_comb begin
    fbits_d = fbits_q;
    fbytes_d = fbytes_q;
    fop_d = fop_q;
    faddr_d = faddr_q;
    fdata_d = fdata_q;
    st_d = st_q;
    pend_d = pend_q;
    pend_sr_d = pend_sr_q;
    dpd_d = dpd_q;
    cnt_d = cnt_q;
    arr_d = arr_q;
    arr_d.valid = 1'b0;
    shadow_d = shadow_q;
    go = 1'b0;
    go_sr = 1'b0;
    kind = sfwp_pkg::SFWP_ARR_PAGE;
    if (cs_s_q[1]) begin
      shadow_d = {dpd_q, st_q};
    end
    if (bit_ev) begin
      fbits_d = fbits_q + 3'h1;
      if (fbits_q == sfwp_pkg::SFWP_SHADOW_BIT) begin
        shadow_d = {dpd_q, st_q};
      end
    end
    if (byte_ev) begin
      fbytes_d = (fbytes_q == 3'h7) ? fbytes_q : fbytes_q + 3'h1;
      if (fbytes_q == 3'h0) begin
        fop_d = byte_q;
      end else if (fbytes_q < sfwp_pkg::SFWP_LEN_ADDR) begin
        faddr_d = {faddr_q[15:0], byte_q};
      end
      if (fbytes_q == sfwp_pkg::SFWP_LEN_OPC) begin
        fdata_d = byte_q;
      end
    end
    if (cs_fall) begin
      fbits_d = 3'h0;
      fbytes_d = 3'h0;
    end
    if (st_q.busy_flag) begin
      cnt_d = cnt_q - 16'h1;
      if (cnt_q == 16'h1) begin
        st_d.busy_flag = 1'b0;
        st_d.write_latch = 1'b0;
        if (pend_sr_q) begin
          st_d.status_lock_mode = pend_q.status_lock_mode;
          st_d.security_lock = st_q.security_lock | pend_q.security_lock;
          st_d.complement_protect = pend_q.complement_protect;
          st_d.protect_size_bits = pend_q.protect_size_bits;
        end
      end
    end
    if (cs_rise) begin
      if (dpd_q) begin
        if (fop_q == sfwp_pkg::SFWP_OPC_PD_EXIT && fbytes_q != 3'h0) begin
          dpd_d = 1'b0;
        end
      end else if (!st_q.busy_flag && fbits_q == 3'h0) begin
        case (fop_q)
          sfwp_pkg::SFWP_OPC_WL_SET: begin
            if (fbytes_q == sfwp_pkg::SFWP_LEN_OPC) st_d.write_latch = 1'b1;
          end
          sfwp_pkg::SFWP_OPC_WL_CLR: begin
            if (fbytes_q == sfwp_pkg::SFWP_LEN_OPC) st_d.write_latch = 1'b0;
          end
          sfwp_pkg::SFWP_OPC_ST_WRITE: begin
            if (fbytes_q == sfwp_pkg::SFWP_LEN_OPC_DATA && st_q.write_latch && !hw_lock) begin
              go = 1'b1;
              go_sr = 1'b1;
              pend_d = sfwp_pkg::sfwp_status_t'(fdata_q);
            end
          end
          sfwp_pkg::SFWP_OPC_PAGE_WR: begin
            go = fbytes_q >= sfwp_pkg::SFWP_LEN_ADDR_DATA && st_q.write_latch && !prot_lo;
          end
          sfwp_pkg::SFWP_OPC_4K_ER: begin
            kind = sfwp_pkg::SFWP_ARR_4K;
            go = fbytes_q == sfwp_pkg::SFWP_LEN_ADDR && st_q.write_latch && !prot_lo;
          end
          sfwp_pkg::SFWP_OPC_32K_ER, sfwp_pkg::SFWP_OPC_64K_ER: begin
            kind = (fop_q == sfwp_pkg::SFWP_OPC_32K_ER) ? sfwp_pkg::SFWP_ARR_32K : sfwp_pkg::SFWP_ARR_64K;
            go = fbytes_q == sfwp_pkg::SFWP_LEN_ADDR && st_q.write_latch && !prot_lo && !prot_hi;
          end
          sfwp_pkg::SFWP_OPC_FULL_ER_A, sfwp_pkg::SFWP_OPC_FULL_ER_B: begin
            kind = sfwp_pkg::SFWP_ARR_FULL;
            go = fbytes_q == sfwp_pkg::SFWP_LEN_OPC && st_q.write_latch && full_ok;
          end
          sfwp_pkg::SFWP_OPC_SECREG_PG: begin
            kind = sfwp_pkg::SFWP_ARR_SECREG_PG;
            go = fbytes_q >= sfwp_pkg::SFWP_LEN_ADDR_DATA && st_q.write_latch && !st_q.security_lock;
          end
          sfwp_pkg::SFWP_OPC_SECREG_ER: begin
            kind = sfwp_pkg::SFWP_ARR_SECREG_ER;
            go = fbytes_q == sfwp_pkg::SFWP_LEN_ADDR && st_q.write_latch && !st_q.security_lock;
          end
          sfwp_pkg::SFWP_OPC_PD_ENTER: begin
            if (fbytes_q == sfwp_pkg::SFWP_LEN_OPC) dpd_d = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
    if (go) begin
      st_d.busy_flag = 1'b1;
      cnt_d = sfwp_pkg::SFWP_OP_CYC;
      pend_sr_d = go_sr;
      if (!go_sr) begin
        arr_d.valid = 1'b1;
        arr_d.kind = kind;
        arr_d.addr = (kind == sfwp_pkg::SFWP_ARR_FULL) ? 24'h000000 : faddr_q;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fbits_q <= 3'h0;
      fbytes_q <= 3'h0;
      fop_q <= 8'h00;
      faddr_q <= 24'h000000;
      fdata_q <= 8'h00;
      st_q <= sfwp_pkg::SFWP_ST_RST;
      pend_q <= sfwp_pkg::SFWP_ST_RST;
      pend_sr_q <= 1'b0;
      dpd_q <= 1'b0;
      cnt_q <= 16'h0000;
      arr_q <= '0;
      shadow_q <= '0;
    end else begin
      fbits_q <= fbits_d;
      fbytes_q <= fbytes_d;
      fop_q <= fop_d;
      faddr_q <= faddr_d;
      fdata_q <= fdata_d;
      st_q <= st_d;
      pend_q <= pend_d;
      pend_sr_q <= pend_sr_d;
      dpd_q <= dpd_d;
      cnt_q <= cnt_d;
      arr_q <= arr_d;
      shadow_q <= shadow_d;
    end
  end

  assign status_o = st_q;
  assign deep_pd_o = dpd_q;
  assign arr_cmd_o = arr_q;

  // ********************************************************
  // checks
  // ********************************************************
  a_latch_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && !dpd_q && !st_q.busy_flag && fop_q == sfwp_pkg::SFWP_OPC_WL_SET && fbits_q == 3'h0 &&
    fbytes_q == 3'h1 |=> st_q.write_latch) else $error("latch not set");
  a_clr_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && st_q.busy_flag && cnt_q != 16'h1 |=> st_q.write_latch == $past(st_q.write_latch))
    else $error("latch changed while busy");
  a_done_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(st_q.busy_flag) |-> !st_q.write_latch) else $error("latch kept after operation");
  a_op_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    arr_q.valid |-> $past(st_q.write_latch) && st_q.busy_flag) else $error("operation without latch");
  a_busy_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(st_q.busy_flag) |-> st_q.busy_flag [*8]) else $error("busy too short");
  a_prot_page: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && !dpd_q && !st_q.busy_flag && fop_q == sfwp_pkg::SFWP_OPC_PAGE_WR && prot_lo
    |=> !arr_q.valid && !st_q.busy_flag) else $error("protected page written");
  a_hw_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && !dpd_q && !st_q.busy_flag && fop_q == sfwp_pkg::SFWP_OPC_ST_WRITE && hw_lock
    |=> !st_q.busy_flag) else $error("locked status accepted");
  a_lock_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(st_q.security_lock) |-> st_q.security_lock) else $error("security lock cleared");
  a_pd_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && dpd_q && fop_q != sfwp_pkg::SFWP_OPC_PD_EXIT |=> dpd_q && $stable(st_q))
    else $error("command acted in power-down");
  a_full_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    arr_q.valid && arr_q.kind == sfwp_pkg::SFWP_ARR_FULL |-> $past(full_ok)) else $error("full erase not allowed");
  a_unaligned: assert property (@(posedge clk_sys) disable iff (!rstn)
    cs_rise && fbits_q != 3'h0 |=> !arr_q.valid ##1 !arr_q.valid) else $error("unaligned command ran");

endmodule

/* design/sfwp_pkg.sv */
package sfwp_pkg;

  // ********************************************************
  // command opcodes
  // ********************************************************
  localparam logic [7:0] SFWP_OPC_WL_SET = 8'h06;
  localparam logic [7:0] SFWP_OPC_WL_CLR = 8'h04;
  localparam logic [7:0] SFWP_OPC_ST_READ = 8'h05;
  localparam logic [7:0] SFWP_OPC_ST_WRITE = 8'h01;
  localparam logic [7:0] SFWP_OPC_PAGE_WR = 8'h02;
  localparam logic [7:0] SFWP_OPC_4K_ER = 8'h20;
  localparam logic [7:0] SFWP_OPC_32K_ER = 8'h52;
  localparam logic [7:0] SFWP_OPC_64K_ER = 8'hd8;
  localparam logic [7:0] SFWP_OPC_FULL_ER_A = 8'h60;
  localparam logic [7:0] SFWP_OPC_FULL_ER_B = 8'hc7;
  localparam logic [7:0] SFWP_OPC_DUAL_RD = 8'h3b;
  localparam logic [7:0] SFWP_OPC_SECREG_ER = 8'h44;
  localparam logic [7:0] SFWP_OPC_SECREG_PG = 8'h42;
  localparam logic [7:0] SFWP_OPC_PD_ENTER = 8'hb9;
  localparam logic [7:0] SFWP_OPC_PD_EXIT = 8'hab;

  // ********************************************************
  // frame lengths in bytes, shadow refresh bit, array geometry
  // ********************************************************
  localparam logic [2:0] SFWP_LEN_OPC = 3'h1;
  localparam logic [2:0] SFWP_LEN_OPC_DATA = 3'h2;
  localparam logic [2:0] SFWP_LEN_ADDR = 3'h4;
  localparam logic [2:0] SFWP_LEN_ADDR_DATA = 3'h5;
  localparam logic [2:0] SFWP_SHADOW_BIT = 3'h3;
  localparam int SFWP_SECTOR_BYTES = 4096;
  localparam int SFWP_SECT_LSB = $clog2(SFWP_SECTOR_BYTES);
  localparam int SFWP_SECT_MSB = 19;
  localparam logic [7:0] SFWP_B32_SECT_MASK = 8'h07;
  localparam logic [7:0] SFWP_B64_SECT_MASK = 8'h0f;
  // protected sector count from sector 0 upward, indexed by size bits
  localparam logic [7:0][8:0] SFWP_PROT_LIM = {9'h100, 9'h0c0, 9'h0e0, 9'h0f0, 9'h0f8, 9'h0fc, 9'h0fe, 9'h000};

  // ********************************************************
  // timing and reset values
  // ********************************************************
  localparam logic [15:0] SFWP_OP_CYC = 16'h03e8;
  localparam logic [7:0] SFWP_ST_RST = 8'h00;

  // ********************************************************
  // types
  // ********************************************************
  typedef struct packed {
    logic status_lock_mode;
    logic security_lock;
    logic complement_protect;
    logic [2:0] protect_size_bits;
    logic write_latch;
    logic busy_flag;
  } sfwp_status_t;

  typedef struct packed {
    logic dpd;
    sfwp_status_t st;
  } sfwp_shadow_t;

  typedef enum logic [2:0] {
    SFWP_ARR_PAGE, SFWP_ARR_4K, SFWP_ARR_32K, SFWP_ARR_64K, SFWP_ARR_FULL, SFWP_ARR_SECREG_PG, SFWP_ARR_SECREG_ER
  } sfwp_arr_kind_t;

  typedef struct packed {
    logic valid;
    sfwp_arr_kind_t kind;
    logic [23:0] addr;
  } sfwp_arr_cmd_t;

endpackage

/* design/sfwp_prot_dec.sv */
`timescale 1ns/100ps

module sfwp_prot_dec (
  input wire logic [2:0] size_bits, // protect size field
  input wire logic compl, // complement protect
  input wire logic [7:0] sector, // sector index
  output logic prot, // sector is protected
  output logic full_er_ok // full array erase allowed
);

  logic [8:0] lim;

  // ********************************************************
  // range decode
  // ********************************************************
  assign lim = sfwp_pkg::SFWP_PROT_LIM[size_bits];
  // complement flips the lower region into the upper remainder
  assign prot = ({1'b0, sector} < lim) ^ compl;
  assign full_er_ok = compl ? (size_bits[2:1] == 2'h3) : (size_bits == 3'h0);

endmodule

/* test/sfwp_host.sv */
`timescale 1ns/100ps

module sfwp_host (
  output logic serial_clock, // link clock, still between frames
  output logic select_n, // chip select, active low
  output logic lane0_drv, // host data toward lane 0
  input wire logic lane0_w, // resolved lane 0
  input wire logic lane1_w // resolved lane 1
);
  logic [47:0] rx0;
  logic [47:0] rx1;

  initial begin
    serial_clock = 1'b0;
    select_n = 1'b1;
    lane0_drv = 1'b0;
    rx0 = 48'h0;
    rx1 = 48'h0;
  end

  // ********************************************************
  // one frame, msb first; mode3 idles the clock high
  // ********************************************************
  task automatic frame(input int nbits, input logic [47:0] tx, input logic mode3);
    serial_clock = mode3;
    #40 select_n = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_clock = 1'b0;
      lane0_drv = tx[i];
      #80 serial_clock = 1'b1;
      rx0 = {rx0[46:0], lane0_w};
      rx1 = {rx1[46:0], lane1_w};
      #80;
    end
    serial_clock = mode3;
    #160 select_n = 1'b1;
    lane0_drv = ~lane0_drv;
    #60;
  endtask
endmodule

/* test/test_sfwp_core.sv */
`timescale 1ns/100ps

module test_sfwp_core;
  localparam int PROT_LOW [8] = '{0, 254, 252, 248, 240, 224, 192, 256};
  localparam logic [7:0] FULL_ST [4] = '{8'h00, 8'h04, 8'h38, 8'h34};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic write_protect_n = 1'b1;
  logic [7:0] array_byte = 8'h00;
  logic serial_clock;
  logic select_n;
  logic lane0_drv;
  logic lane0_o;
  logic lane0_oe;
  logic lane1_o;
  logic lane1_oe;
  logic deep_pd;
  logic [7:0] st_exp = 8'h00;
  sfwp_pkg::sfwp_status_t status;
  sfwp_pkg::sfwp_arr_cmd_t arr_cmd;
  sfwp_pkg::sfwp_arr_cmd_t last_arr;
  int n_errors = 0;
  int checks = 0;
  int n_arr = 0;
  // host lets go of lane 0 while the device drives it
  wire lane0_w = lane0_oe ? lane0_o : lane0_drv;
  wire lane1_w = lane1_oe ? lane1_o : ~lane1_o;

  sfwp_host u_sfwp_host (.serial_clock(serial_clock), .select_n(select_n), .lane0_drv(lane0_drv),
    .lane0_w(lane0_w), .lane1_w(lane1_w));
  sfwp_core u_sfwp_core (.clk_sys(clk_sys), .rstn(rstn), .serial_clock(serial_clock), .select_n(select_n),
    .write_protect_n(write_protect_n), .dual_lane0_i(lane0_w), .dual_lane0_o(lane0_o),
    .dual_lane0_oe(lane0_oe), .dual_lane1_o(lane1_o), .dual_lane1_oe(lane1_oe), .array_byte(array_byte),
    .status_o(status), .deep_pd_o(deep_pd), .arr_cmd_o(arr_cmd));

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (arr_cmd.valid === 1'b1) begin
      n_arr <= n_arr + 1;
      last_arr <= arr_cmd;
    end
  end

  // ********************************************************
  // compares and verdict
  // ********************************************************
  task automatic check_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [27:0] got, input logic [27:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ********************************************************
  // link access
  // ********************************************************
  task automatic send(input int nbits, input logic [47:0] tx, input logic mode3 = 1'b0);
    u_sfwp_host.frame(nbits, tx, mode3);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (status.busy_flag !== 1'b0 && k < 1200) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 1200) begin
      n_errors++;
      $display("Error at %0t: busy stuck", $time);
      finish_test();
    end
  endtask

  task automatic rd_status(input logic [7:0] exp, input logic mode3);
    send(24, {24'h0, sfwp_pkg::SFWP_OPC_ST_READ, 16'h0}, mode3);
    check_word(28'(u_sfwp_host.rx1[15:8]), 28'(exp), "rd0");
    check_word(28'(u_sfwp_host.rx1[7:0]), 28'(exp), "rd1");
  endtask

  task automatic wr_status(input logic [7:0] v, input logic ok, input logic [7:0] nv);
    send(8, 48'h06);
    send(16, {32'h0, sfwp_pkg::SFWP_OPC_ST_WRITE, v});
    check_bit(status.busy_flag, ok, "wr busy");
    if (ok)
      rd_status({st_exp[7:2], 2'b11}, 1'b0);
    wait_idle();
    if (ok)
      st_exp = nv;
    check_word(28'(status[7:2]), 28'(st_exp[7:2]), "st bits");
    if (ok)
      check_bit(status.write_latch, 1'b0, "wr lat");
  endtask

  task automatic arr_op(input logic [7:0] opc, input int s, input logic ok);
    logic full;
    logic [23:0] a;
    int n0;
    sfwp_pkg::sfwp_arr_kind_t kind;
    full = (opc == sfwp_pkg::SFWP_OPC_FULL_ER_A);
    a = full ? 24'h0 : {4'h0, s[7:0], 12'h5a3};
    kind = full ? sfwp_pkg::SFWP_ARR_FULL : (opc == sfwp_pkg::SFWP_OPC_PAGE_WR) ? sfwp_pkg::SFWP_ARR_PAGE :
      (opc == sfwp_pkg::SFWP_OPC_64K_ER) ? sfwp_pkg::SFWP_ARR_64K : sfwp_pkg::SFWP_ARR_4K;
    n0 = n_arr;
    send(8, 48'h06);
    if (full)
      send(8, {40'h0, opc});
    else if (opc == sfwp_pkg::SFWP_OPC_PAGE_WR)
      send(40, {8'h0, opc, a, 8'ha5});
    else
      send(32, {16'h0, opc, a});
    check_bit(status.busy_flag, ok, "op busy");
    check_bit(n_arr == n0 + 1, ok, "op issued");
    if (ok)
      check_word(last_arr, {1'b1, kind, a}, "op target");
    wait_idle();
    check_bit(status.write_latch, !ok, "op lat");
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    check_word(28'(status), 28'h0, "reset st");
    check_bit(deep_pd, 1'b0, "reset pd");
    send(16, {32'h0, sfwp_pkg::SFWP_OPC_ST_WRITE, 8'h1c});
    check_bit(status.busy_flag, 1'b0, "no latch busy");
    check_word(28'(status), 28'h0, "no latch st");
    send(9, 48'h00c);
    check_bit(status.write_latch, 1'b0, "odd count");
    send(8, 48'h06);
    check_bit(status.write_latch, 1'b1, "lat set");
    rd_status(8'h02, 1'b1);
    send(8, 48'h04);
    check_bit(status.write_latch, 1'b0, "lat clr");
    for (int c = 0; c < 2; c++) begin
      for (int b = 0; b < 8; b++) begin
        wr_status({2'b00, c[0], b[2:0], 2'b00}, 1'b1, {2'b00, c[0], b[2:0], 2'b00});
        if (PROT_LOW[b] > 0)
          arr_op(sfwp_pkg::SFWP_OPC_4K_ER, PROT_LOW[b] - 1, c[0]);
        if (PROT_LOW[b] < 256)
          arr_op(sfwp_pkg::SFWP_OPC_4K_ER, PROT_LOW[b], !c[0]);
      end
    end
    foreach (FULL_ST[i]) begin
      wr_status(FULL_ST[i], 1'b1, FULL_ST[i]);
      arr_op(sfwp_pkg::SFWP_OPC_FULL_ER_A, 0, (FULL_ST[i][4:2] == 3'h0 && !FULL_ST[i][5]) ||
        (FULL_ST[i][4:3] == 2'h3 && FULL_ST[i][5]));
    end
    arr_op(sfwp_pkg::SFWP_OPC_PAGE_WR, 224, 1'b0);
    arr_op(sfwp_pkg::SFWP_OPC_PAGE_WR, 223, 1'b1);
    wr_status(8'h24, 1'b1, 8'h24);
    arr_op(sfwp_pkg::SFWP_OPC_64K_ER, 240, 1'b0);
    send(8, 48'h04);
    check_bit(status.write_latch, 1'b0, "lat clr pd");
    send(8, {40'h0, sfwp_pkg::SFWP_OPC_PD_ENTER});
    check_bit(deep_pd, 1'b1, "pd on");
    send(8, 48'h06);
    check_bit(status.write_latch, 1'b0, "pd ignores");
    send(8, {40'h0, sfwp_pkg::SFWP_OPC_PD_EXIT});
    check_bit(deep_pd, 1'b0, "pd off");
    @(posedge clk_sys);
    array_byte <= 8'hb4;
    #1;
    send(44, {4'h0, sfwp_pkg::SFWP_OPC_DUAL_RD, 24'h001234, 8'h00, 4'h0});
    for (int i = 0; i < 4; i++) begin
      check_bit(u_sfwp_host.rx1[3 - i], array_byte[7 - 2 * i], "lane1");
      check_bit(u_sfwp_host.rx0[3 - i], array_byte[6 - 2 * i], "lane0");
    end
    wr_status(8'hc0, 1'b1, 8'hc0);
    @(posedge clk_sys);
    write_protect_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    wr_status(8'h1c, 1'b0, 8'h00);
    @(posedge clk_sys);
    write_protect_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    wr_status(8'h00, 1'b1, 8'h40);
    finish_test();
  end
endmodule
